//--- rtl/line_ctrl_regs.sv
// Line ownership, output-enable and glitch-filter registers of the I/O line controller
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module line_ctrl_regs
	import line_ctrl_pkg::*;
#(
	parameter logic [LINES-1:0] OWN_RESET = OWN_RESET_A,
	parameter int FILT_HOLD = FILT_CYC
)(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [LINES-1:0] pin_in_i,
	input wire logic [LINES-1:0] line_data_i,
	input wire logic [LINES-1:0] per_out_i,
	input wire logic [LINES-1:0] per_oe_i,
	output logic [LINES-1:0] pin_out_o,
	output logic [LINES-1:0] pin_oe_o,
	output logic [LINES-1:0] per_in_o,
	output logic [LINES-1:0] line_in_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [LINES-1:0] own_r;
	logic [LINES-1:0] own_nxt;
	logic [LINES-1:0] oe_r;
	logic [LINES-1:0] oe_nxt;
	logic [LINES-1:0] filt_r;
	logic [LINES-1:0] filt_nxt;
	logic [LINES-1:0] level_w;

	reg_xfer_if rif ();

	// ----------------------------------------
	// Bus port
	// ----------------------------------------
	apb_slave_port u_port (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.rif(rif)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Write-only offsets are mapped so writes land; they read as zero
	function automatic logic at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		at = (a == off);
	endfunction : at

	wire sel_grant = at(rif.addr, OFF_OWN_GRANT);
	wire sel_revoke = at(rif.addr, OFF_OWN_REVOKE);
	wire sel_own_st = at(rif.addr, OFF_OWN_STATUS);
	wire sel_oe_set = at(rif.addr, OFF_OE_SET);
	wire sel_oe_clr = at(rif.addr, OFF_OE_CLEAR);
	wire sel_oe_st = at(rif.addr, OFF_OE_STATUS);
	wire sel_f_set = at(rif.addr, OFF_FILT_SET);
	wire sel_f_clr = at(rif.addr, OFF_FILT_CLEAR);
	wire sel_f_st = at(rif.addr, OFF_FILT_STATUS);

	assign rif.hit = sel_grant | sel_revoke | sel_own_st | sel_oe_set | sel_oe_clr
		| sel_oe_st | sel_f_set | sel_f_clr | sel_f_st;

	// Full-word status reads, bit n is line n
	assign rif.rdata = ({DATA_W{sel_own_st}} & own_r)
		| ({DATA_W{sel_oe_st}} & oe_r)
		| ({DATA_W{sel_f_st}} & filt_r);

	// ----------------------------------------
	// Set/clear write masks
	// ----------------------------------------
	// Set and clear sit at different offsets, so they never meet in one cycle
	function automatic logic [LINES-1:0] set_clr(input logic [LINES-1:0] cur, input logic do_set,
		input logic do_clr, input logic [LINES-1:0] mask);
		set_clr = do_set ? (cur | mask) : (do_clr ? (cur & ~mask) : cur);
	endfunction : set_clr

	wire wr_grant = rif.wr_en & sel_grant;
	wire wr_revoke = rif.wr_en & sel_revoke;
	wire wr_oe_set = rif.wr_en & sel_oe_set;
	wire wr_oe_clr = rif.wr_en & sel_oe_clr;
	wire wr_f_set = rif.wr_en & sel_f_set;
	wire wr_f_clr = rif.wr_en & sel_f_clr;

	assign own_nxt = set_clr(own_r, wr_grant, wr_revoke, rif.wdata);
	assign oe_nxt = set_clr(oe_r, wr_oe_set, wr_oe_clr, rif.wdata);
	assign filt_nxt = set_clr(filt_r, wr_f_set, wr_f_clr, rif.wdata);

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Enables are stored whoever owns the line, ready for when it returns
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			own_r <= OWN_RESET;
			oe_r <= OE_RESET;
			filt_r <= FILT_RESET;
		end else begin
			own_r <= own_nxt;
			oe_r <= oe_nxt;
			filt_r <= filt_nxt;
		end
	end

	// ----------------------------------------
	// Input path
	// ----------------------------------------
	// Filtering sits before the ownership split, so it serves both owners
	input_glitch_filter #(
		.WIDTH(LINES),
		.HOLD(FILT_HOLD)
	) u_filter (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pin_i(pin_in_i),
		.filt_en_i(filt_r),
		.level_o(level_w)
	);

	// ----------------------------------------
	// Pin muxing
	// ----------------------------------------
	wire [LINES-1:0] oe_sel_w = (own_r & oe_r) | (~own_r & per_oe_i);
	wire [LINES-1:0] out_sel_w = (own_r & line_data_i) | (~own_r & per_out_i);
	wire [LINES-1:0] per_in_w = level_w & ~own_r;

	// One flop stage on every pin-facing output keeps them glitch free
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pin_oe_o <= '0;
			pin_out_o <= '0;
			per_in_o <= '0;
			line_in_o <= '0;
		end else begin
			pin_oe_o <= oe_sel_w;
			pin_out_o <= out_sel_w;
			per_in_o <= per_in_w;
			line_in_o <= level_w;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	logic rst_seen_r;
	always_ff @(posedge clk_i) begin
		rst_seen_r <= !nrst_i;
	end

	chk_reset_values: assert property (disable iff (1'b0)
		rst_seen_r |-> (own_r == OWN_RESET && oe_r == OE_RESET && filt_r == FILT_RESET))
		else $error("Register reset values wrong");

	chk_own_grant: assert property (wr_grant |=>
		own_r == ($past(own_r) | $past(rif.wdata)))
		else $error("Grant write did not set ownership bits");

	chk_own_revoke: assert property (wr_revoke |=>
		own_r == ($past(own_r) & ~$past(rif.wdata)))
		else $error("Revoke write did not clear ownership bits");

	chk_oe_set_bits: assert property (wr_oe_set |=>
		oe_r == ($past(oe_r) | $past(rif.wdata)))
		else $error("Output-enable set write wrong");

	chk_oe_clear_bits: assert property (wr_oe_clr |=>
		oe_r == ($past(oe_r) & ~$past(rif.wdata)))
		else $error("Output-enable clear write wrong");

	chk_filt_set_bits: assert property (wr_f_set |=>
		filt_r == ($past(filt_r) | $past(rif.wdata)))
		else $error("Filter set write wrong");

	chk_filt_clear_bits: assert property (wr_f_clr |=>
		filt_r == ($past(filt_r) & ~$past(rif.wdata)))
		else $error("Filter clear write wrong");

	chk_no_stray_change: assert property (!rif.wr_en |=>
		$stable(oe_r) && $stable(filt_r) && $stable(own_r))
		else $error("Control register changed without a write");

	// Sampled reset in the antecedent keeps the release edge, whose pins still show reset, out of the check
	chk_pin_direction: assert property (nrst_i |=>
		pin_oe_o == (($past(own_r) & $past(oe_r)) | (~$past(own_r) & $past(per_oe_i))))
		else $error("Pin direction not taken from the owner");

	chk_per_in_zero: assert property (nrst_i |=>
		(per_in_o & $past(own_r)) == '0)
		else $error("Peripheral input not held low on owned line");

	chk_status_read: assert property (
		(psel_i && penable_i && !pready_o && !pwrite_i && sel_oe_st) ##1 pready_o |->
		prdata_o == $past(oe_r))
		else $error("Output-enable status read returned wrong data");

	chk_own_read: assert property (
		(psel_i && penable_i && !pready_o && !pwrite_i && sel_own_st) |=>
		pready_o && prdata_o == $past(own_r))
		else $error("Ownership status read returned wrong data");

	// ----------------------------------------
	// Bus answer checks
	// ----------------------------------------
	// Helper terms shared by the checks below
	wire first_acc_w = psel_i & penable_i & ~pready_o;
	wire wo_sel_w = sel_grant | sel_revoke | sel_oe_set | sel_oe_clr | sel_f_set | sel_f_clr;
	wire st_sel_w = sel_own_st | sel_oe_st | sel_f_st;

	// The port always inserts exactly one wait state
	chk_ready_one_wait: assert property (
		first_acc_w |=> pready_o)
		else $error("Ready did not follow the wait state");

	// Ready is a pulse; a held ready would commit a write twice
	chk_ready_one_cycle: assert property (
		pready_o |=> !pready_o)
		else $error("Ready stood for more than one cycle");

	// Ready only answers a request that was already in its access phase
	chk_ready_has_req: assert property (
		pready_o |-> $past(psel_i) && $past(penable_i))
		else $error("Ready without a preceding access cycle");

	// Unmapped offsets, misaligned ones included, answer with an error
	chk_error_unmapped: assert property (
		(first_acc_w && !rif.hit) |=> pready_o && pslverr_o)
		else $error("Unmapped access not flagged");

	// Mapped offsets never raise an error, status writes included
	chk_error_mapped: assert property (
		(first_acc_w && rif.hit) |=> !pslverr_o)
		else $error("Mapped access flagged as an error");

	// The error flag only ever rides on the ready pulse
	chk_error_with_ready: assert property (
		pslverr_o |-> pready_o)
		else $error("Error flag outside the ready cycle");

	// A write commits only on the ready edge and only to a mapped offset
	chk_write_commit: assert property (
		rif.wr_en |-> rif.hit && pready_o && pwrite_i && psel_i && penable_i)
		else $error("Write committed outside a mapped ready cycle");

	// Read data is zero whenever no read answer stands
	chk_rdata_idle: assert property (
		!pready_o |-> prdata_o == '0)
		else $error("Read data not zero outside the ready cycle");

	// A write answer carries no data
	chk_rdata_on_write: assert property (
		(pready_o && pwrite_i) |-> prdata_o == '0)
		else $error("Read data not zero on a write answer");

	// Filter status follows the stored selection, bit n for line n
	chk_filt_read: assert property (
		(first_acc_w && !pwrite_i && sel_f_st) |=>
		pready_o && prdata_o == $past(filt_r))
		else $error("Filter status read returned wrong data");

	// Write-only offsets read back as zero without an error
	chk_wo_read_zero: assert property (
		(first_acc_w && !pwrite_i && wo_sel_w) |=>
		pready_o && !pslverr_o && prdata_o == '0)
		else $error("Write-only offset did not read as zero");

	// ----------------------------------------
	// Register and pin checks
	// ----------------------------------------
	// Status offsets are read-only: a write there is accepted and ignored
	chk_status_write_void: assert property (
		(rif.wr_en && st_sel_w) |=>
		$stable(own_r) && $stable(oe_r) && $stable(filt_r))
		else $error("Write to a status offset changed a register");

	// Ownership moves only on grant and revoke writes
	chk_own_by_grant: assert property (
		!(wr_grant || wr_revoke) |=> $stable(own_r))
		else $error("Ownership changed without a grant or revoke");

	// Enables written for peripheral lines are stored all the same
	chk_oe_stored_per: assert property (
		wr_oe_set |=>
		(oe_r & $past(rif.wdata & ~own_r)) == $past(rif.wdata & ~own_r))
		else $error("Enable for a peripheral line not stored");

	// A set enable on an owned line reaches the pin two edges after the commit
	chk_oe_set_pin: assert property (
		wr_oe_set |=> ##1
		(pin_oe_o & $past(own_r, 2) & $past(rif.wdata, 2)) == ($past(own_r, 2) & $past(rif.wdata, 2)))
		else $error("Set enable did not reach an owned pin");

	// A cleared enable on an owned line releases the pin two edges after the commit
	chk_oe_clear_pin: assert property (
		wr_oe_clr |=> ##1
		(pin_oe_o & $past(own_r, 2) & $past(rif.wdata, 2)) == '0)
		else $error("Cleared enable still drives an owned pin");

	// A granted line stops feeding its peripheral two edges after the commit
	chk_grant_per_zero: assert property (
		wr_grant |=> ##1 (per_in_o & $past(rif.wdata, 2)) == '0)
		else $error("Granted line still feeds its peripheral");

	// Output level comes from the owner of the line
	chk_pin_out_owner: assert property (
		nrst_i |=>
		pin_out_o == (($past(own_r) & $past(line_data_i)) | (~$past(own_r) & $past(per_out_i))))
		else $error("Pin output not taken from the owner");

	// The controller sees the filtered level one edge after the filter
	chk_line_in_level: assert property (
		nrst_i |=> line_in_o == $past(level_w))
		else $error("Controller input not the filtered level");

	// Peripherals see the same filtered level on the lines they own
	chk_per_in_level: assert property (
		nrst_i |=> per_in_o == ($past(level_w) & ~$past(own_r)))
		else $error("Peripheral input not the filtered level");

	cov_oe_on_owned: cover property (wr_oe_set ##1 (pin_oe_o & own_r) != '0);
	cov_oe_on_peripheral: cover property (wr_oe_set && (rif.wdata & ~own_r) != '0);
	cov_filter_then_grant: cover property (wr_f_set ##[1:20] wr_grant);
	cov_unmapped_error: cover property (pslverr_o && pready_o);

endmodule : line_ctrl_regs

//--- common/line_ctrl_pkg.sv
// Shared constants for the 32-line I/O line controller register block
package line_ctrl_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int LINES = 32;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFF_OWN_GRANT = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_OWN_REVOKE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_OWN_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_OE_SET = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OE_CLEAR = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_OE_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_FILT_SET = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_FILT_CLEAR = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_FILT_STATUS = 8'h28;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [LINES-1:0] OWN_RESET_A = 32'h3dffffff;
	localparam logic [LINES-1:0] OWN_RESET_B = 32'h00ffffc0;
	localparam logic [LINES-1:0] OE_RESET = 32'h00000000;
	localparam logic [LINES-1:0] FILT_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam int FILT_CYC = 2; // Cycles a level must hold to pass the filter

endpackage : line_ctrl_pkg

//--- common/reg_xfer_if.sv
// Decoded register transfer between the bus port and the register core
`timescale 1ns/100ps
interface reg_xfer_if;
	import line_ctrl_pkg::*;

	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic wr_en;
	logic [DATA_W-1:0] rdata;
	logic hit;

	modport port (output addr, output wdata, output wr_en, input rdata, input hit);
	modport core (input addr, input wdata, input wr_en, output rdata, output hit);

endinterface : reg_xfer_if

//--- rtl/apb_slave_port.sv
// APB slave with one wait state, feeding the register core
`timescale 1ns/100ps
module apb_slave_port
	import line_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	reg_xfer_if.port rif
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// First access cycle inserts a wait; the second completes the transfer
	wire access_w = psel_i & penable_i;
	wire first_w = access_w & ~pready_o;
	wire done_w = access_w & pready_o;

	assign rif.addr = paddr_i;
	assign rif.wdata = pwdata_i;
	assign rif.wr_en = done_w & pwrite_i & rif.hit; // Commits on the sampled-ready edge

	// ----------------------------------------
	// Answer registers
	// ----------------------------------------
	// Read data is captured in the wait cycle so outputs come from flops
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pready_o <= 1'b0;
			prdata_o <= RDATA_RESET;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= first_w;
			prdata_o <= (first_w && !pwrite_i) ? rif.rdata : RDATA_RESET;
			pslverr_o <= first_w & ~rif.hit;
		end
	end

endmodule : apb_slave_port

//--- rtl/input_glitch_filter.sv
// Per-line input synchroniser with selectable glitch filter
`timescale 1ns/100ps
module input_glitch_filter
	import line_ctrl_pkg::*;
#(
	parameter int WIDTH = LINES,
	parameter int HOLD = FILT_CYC
)(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] pin_i,
	input wire logic [WIDTH-1:0] filt_en_i,
	output logic [WIDTH-1:0] level_o
);

	localparam int CW = $clog2(HOLD + 1);
	localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD - 1);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] stable_r;
	logic [CW-1:0] cnt_r [WIDTH];

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	// Pins are asynchronous; only sync_r reads meta_r
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
		end
	end

	// ----------------------------------------
	// Stability counters
	// ----------------------------------------
	// A new level is accepted only after holding HOLD cycles
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (!nrst_i || sync_r[i] == stable_r[i]) begin
				cnt_r[i] <= '0;
			end else if (cnt_r[i] == HOLD_LAST) begin
				cnt_r[i] <= '0;
			end else begin
				cnt_r[i] <= cnt_r[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (!nrst_i) begin
				stable_r[i] <= 1'b0;
			end else if (sync_r[i] != stable_r[i] && cnt_r[i] == HOLD_LAST) begin
				stable_r[i] <= sync_r[i];
			end
		end
	end

	// Unfiltered lines bypass the counter and keep their short latency
	assign level_o = (filt_en_i & stable_r) | (~filt_en_i & sync_r);

endmodule : input_glitch_filter

//--- test/pin_side_model.sv
// Pins and on-chip peripherals on the far side of the line controller
`timescale 1ns/100ps
module pin_side_model
	import line_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic quiet_i,
	input wire logic [LINES-1:0] ext_level_i,
	input wire logic [LINES-1:0] pin_out_i,
	input wire logic [LINES-1:0] pin_oe_i,
	output logic [LINES-1:0] pin_level_o,
	output logic [LINES-1:0] line_data_o,
	output logic [LINES-1:0] per_out_o,
	output logic [LINES-1:0] per_oe_o
);
	int seed = 19381;

	// ----------------------------------------
	// Peripheral traffic
	// ----------------------------------------
	// Noisy every cycle; quiet mode releases the peripheral drivers so their pins follow the outside level
	always @(posedge clk_i) begin
		line_data_o <= $random(seed);
		per_out_o <= quiet_i ? '0 : $random(seed);
		per_oe_o <= quiet_i ? '0 : $random(seed);
	end

	// ----------------------------------------
	// Pin level
	// ----------------------------------------
	// A driven pin shows its driver, an undriven one the outside level
	assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_level_i);

endmodule : pin_side_model

//--- test/tb_top.sv
// Self-checking bench for the ownership, output-enable and filter registers
`timescale 1ns/100ps
module tb_top
	import line_ctrl_pkg::*;
;
	logic clk_i = 0;
	logic nrst_i = 0;
	logic psel = 0;
	logic pen = 0;
	logic pwr = 0;
	logic quiet = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [LINES-1:0] ext = '0;
	logic [LINES-1:0] own_m, oe_m, filt_m, p_oe, p_out, p_ld, sl, sp;
	logic [ADDR_W-1:0] offs [6];
	wire logic [DATA_W-1:0] prdata;
	wire logic pready, pslverr;
	wire logic [LINES-1:0] pin_in, ld, po, poe, pin_out, pin_oe, per_in, line_in;
	int seed = 19381;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;

	always #25 clk_i = ~clk_i;

	line_ctrl_regs #(.OWN_RESET(OWN_RESET_A), .FILT_HOLD(2)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in),
		.line_data_i(ld), .per_out_i(po), .per_oe_i(poe), .pin_out_o(pin_out),
		.pin_oe_o(pin_oe), .per_in_o(per_in), .line_in_o(line_in));

	pin_side_model peer (.clk_i(clk_i), .quiet_i(quiet), .ext_level_i(ext), .pin_out_i(pin_out),
		.pin_oe_i(pin_oe), .pin_level_o(pin_in), .line_data_o(ld), .per_out_o(po), .per_oe_o(poe));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Keep what the pin flops sampled, and cut a hang short
	always @(posedge clk_i) begin
		p_oe <= poe;
		p_out <= po;
		p_ld <= ld;
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	task results;
		if (num_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One APB transfer; request held until pready is sampled high
	task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] r, output logic e);
		@(posedge clk_i);
		psel <= 1'h1;
		pen <= 1'h0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'h1;
		do @(posedge clk_i); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : xfer

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		logic e;
		xfer(1'h1, a, d, r, e);
		check("write error", {31'h0, e}, 32'h0);
	endtask : wr

	task rd_chk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] r;
		logic e;
		xfer(1'h0, a, 32'h0, r, e);
		check(n, r, exp);
	endtask : rd_chk

	task statuses;
		rd_chk("owner status", OFF_OWN_STATUS, own_m);
		rd_chk("oe status", OFF_OE_STATUS, oe_m);
		rd_chk("filter status", OFF_FILT_STATUS, filt_m);
	endtask : statuses

	// Pins settle one edge after what the flops sampled
	task watch(input int n);
		repeat (n) begin
			@(negedge clk_i);
			check("pin oe", pin_oe, (own_m & oe_m) | (~own_m & p_oe));
			check("pin out", pin_out, (own_m & p_ld) | (~own_m & p_out));
			check("peripheral input", per_in & own_m, 32'h0);
		end
	endtask : watch

	function automatic logic [31:0] nxt(input logic [31:0] c, input logic s, input logic [31:0] d);
		return s ? (c | d) : (c & ~d);
	endfunction : nxt

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Zero masks first, then all ones, then random, so no-effect bits are exercised too
	initial begin
		logic [31:0] d, r;
		logic e;
		offs = '{OFF_OWN_GRANT, OFF_OWN_REVOKE, OFF_OE_SET, OFF_OE_CLEAR, OFF_FILT_SET, OFF_FILT_CLEAR};
		own_m = OWN_RESET_A;
		oe_m = '0;
		filt_m = '0;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'h1;
		statuses();
		xfer(1'h0, 8'h0c, 32'h0, r, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		check("unmapped data", r, 32'h0);
		xfer(1'h0, OFF_FILT_SET, 32'h0, r, e);
		check("write-only read data", r, 32'h0);
		check("write-only read error", {31'h0, e}, 32'h0);
		wr(OFF_OWN_STATUS, 32'hffffffff);
		wr(OFF_OE_STATUS, 32'hffffffff);
		statuses();
		for (int i = 0; i < 30; i++) begin
			if (i < 6) d = 32'h0;
			else if (i < 12) d = 32'hffffffff;
			else d = $random(seed);
			wr(offs[i % 6], d);
			if (i % 6 < 2) own_m = nxt(own_m, i % 2 == 0, d);
			else if (i % 6 < 4) oe_m = nxt(oe_m, i % 2 == 0, d);
			else filt_m = nxt(filt_m, i % 2 == 0, d);
			statuses();
			watch(6);
		end
		// Filter on the low half only; a one-cycle pulse must vanish there
		quiet <= 1'h1;
		wr(OFF_OE_CLEAR, 32'hffffffff);
		wr(OFF_FILT_SET, 32'h0000ffff);
		wr(OFF_FILT_CLEAR, 32'hffff0000);
		oe_m = '0;
		filt_m = 32'h0000ffff;
		statuses();
		repeat (8) @(posedge clk_i);
		ext <= '1;
		@(posedge clk_i);
		ext <= '0;
		sl = '0;
		sp = '0;
		repeat (10) begin
			@(negedge clk_i);
			sl = sl | line_in;
			sp = sp | per_in;
		end
		check("short pulse line", sl, 32'hffff0000);
		check("short pulse peripheral", sp, 32'hffff0000 & ~own_m);
		@(posedge clk_i);
		ext <= '1;
		repeat (10) @(negedge clk_i);
		check("long level line", line_in, 32'hffffffff);
		check("long level peripheral", per_in, ~own_m);
		// Reset in mid-run brings every register back to its value after reset
		@(posedge clk_i);
		nrst_i <= 1'h0;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'h1;
		own_m = OWN_RESET_A;
		oe_m = '0;
		filt_m = '0;
		statuses();
		watch(6);
		results();
	end

endmodule : tb_top
